// >>> hw/tkrha_regs.sv
// Host register bank: pointer, slot selection, configuration
//
// Behaviour
// - Pointer-high bit 7 picks the direction of the next buffer access, 1 read and 0 write.
// - Pointer-high bit 6 makes the buffer pointer step by one after every data access in the direction that bit 7 selects.
// - Pointer-high bits 2-0 give buffer address bits 10-8 and bits 5-3 carry nothing.
// - Pointer-low bits 7-0 give buffer address bits 7-0 of the 11-bit address.
// - The two low slot code bits are one store seen through selector and configuration.
// - Every configuration write clears the top slot code bit.
// - Configuration bit 7 holds the device in soft reset until software writes it back to 0.
// - Soft reset clears only status, next identifier and diagnostic status.
// - Configuration bit 6 enables chained command operation.
// - With configuration bit 5 low the pulse a and driver outputs stay inactive, and pulse b does too unless configuration bit 2 is set.
// - Configuration bits 4 and 3 select extended timeouts for the protocol engine.
// - Configuration bit 2 selects backplane line signalling.
//
// Our own choices: strobed register access and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module tkrha_regs
  import tkrha_pkg::*;
#(
  parameter int unsigned AW = BUF_ADDR_W
) (
  input  wire logic               clk,
  input  wire logic               reset,
  // Host register port
  input  wire logic [ADDR_W-1:0]  reg_addr,
  input  wire logic [DATA_W-1:0]  reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output logic [DATA_W-1:0]       reg_rdata,
  // Protocol engine side
  input  wire logic [DATA_W-1:0]  status_set,
  input  wire logic [DATA_W-1:0]  diag_set,
  input  wire logic               next_id_load,
  input  wire logic [DATA_W-1:0]  next_id_value,
  input  wire logic               tx_pulse_a,
  input  wire logic               tx_pulse_b,
  input  wire logic               tx_driver,
  output logic                    soft_reset,
  output logic                    chained_command_enable,
  output logic                    timeout_ext_hi,
  output logic                    timeout_ext_lo,
  output logic                    backplane_mode,
  output logic                    line_drive_enable,
  output logic [DATA_W-1:0]       node_id,
  output logic [DATA_W-1:0]       tentative_id,
  output logic [DATA_W-1:0]       setup_1,
  output logic [DATA_W-1:0]       setup_2,
  output logic [AW-1:0]           buffer_address,
  output logic                    access_direction,
  output logic                    pointer_step_enable,
  // Line pins, active low
  output logic                    line_pulse_a_n,
  output logic                    line_pulse_b_n,
  output logic                    driver_enable_n
);

  // Configuration storage excludes the shared slot bits
  logic [CFG_KEEP_MSB:CFG_KEEP_LSB] cfg_r;
  logic                             sel_msb_r;
  logic [SEL_LOW_W-1:0]             sel_low_r;
  logic [DATA_W-1:0]                status_r;
  logic [DATA_W-1:0]                status_nxt;
  logic [DATA_W-1:0]                diag_r;
  logic [DATA_W-1:0]                diag_nxt;
  logic [DATA_W-1:0]                next_id_r;
  logic [DATA_W-1:0]                tent_id_r;
  logic [DATA_W-1:0]                node_id_r;
  logic [DATA_W-1:0]                setup_1_r;
  logic [DATA_W-1:0]                setup_2_r;
  logic [DATA_W-1:0]                rdata_r;
  logic [DATA_W-1:0]                rdata_nxt;

  // Address decode
  logic                             hit_status;
  logic                             hit_diag;
  logic                             hit_ptr_high;
  logic                             hit_ptr_low;
  logic                             hit_data;
  logic                             hit_sel;
  logic                             hit_cfg;
  logic                             hit_slot;
  logic [2:0]                       slot_code;
  logic                             slot_reserved;
  logic                             slot_we;
  logic [DATA_W-1:0]                slot_q;
  logic [DATA_W-1:0]                cfg_view;
  logic [DATA_W-1:0]                sel_view;
  logic [DATA_W-1:0]                ptr_high_view;
  logic [DATA_W-1:0]                ptr_low_view;
  logic [DATA_W-1:0]                ram_q;
  logic                             soft_rst;
  logic [LINE_CH-1:0]               line_req;
  logic [LINE_CH-1:0]               line_n;

  // Offset decoding, one offset per register
  assign hit_status   = (reg_addr == OFF_STATUS);
  assign hit_diag     = (reg_addr == OFF_DIAG);
  assign hit_ptr_high = (reg_addr == OFF_PTR_HIGH);
  assign hit_ptr_low  = (reg_addr == OFF_PTR_LOW);
  assign hit_data     = (reg_addr == OFF_BUF_DATA);
  assign hit_sel      = (reg_addr == OFF_SLOT_SEL);
  assign hit_cfg      = (reg_addr == OFF_CONFIG);
  assign hit_slot     = (reg_addr == OFF_SLOT);

  // Slot code is the shared low pair plus the lone top bit
  assign slot_code     = {sel_msb_r, sel_low_r};
  assign slot_reserved = (slot_code > SLOT_SETUP_2);
  assign slot_we       = reg_wr & hit_slot & ~slot_reserved;

  // Soft reset is a level that lasts while the bit stays set
  assign soft_rst = cfg_r[CFG_SOFT_RESET_BIT];

  // Configuration register; slot top bit cleared on every write
  always_ff @(posedge clk) begin
    if (reset) begin
      cfg_r <= CONFIG_RESET[CFG_KEEP_MSB:CFG_KEEP_LSB];
    end else if (reg_wr && hit_cfg) begin
      cfg_r <= reg_wdata[CFG_KEEP_MSB:CFG_KEEP_LSB];
    end
  end

  // Shared slot selector bits; the config port reaches only the low pair
  always_ff @(posedge clk) begin
    if (reset) begin
      sel_msb_r <= SEL_RESET[2];
      sel_low_r <= SEL_RESET[SEL_LOW_W-1:0];
    end else if (reg_wr && hit_cfg) begin
      sel_msb_r <= 1'b0;
      sel_low_r <= reg_wdata[SEL_LOW_W-1:0];
    end else if (reg_wr && hit_sel) begin
      sel_msb_r <= reg_wdata[2];
      sel_low_r <= reg_wdata[SEL_LOW_W-1:0];
    end
  end

  // Sticky engine flags; soft reset and power reset clear them
  assign status_nxt = status_r | status_set;
  assign diag_nxt   = diag_r | diag_set;

  always_ff @(posedge clk) begin
    if (reset || soft_rst) begin
      status_r <= REG_RESET;
      diag_r   <= REG_RESET;
    end else begin
      status_r <= status_nxt;
      diag_r   <= diag_nxt;
    end
  end

  // Next identifier is written by the engine only
  always_ff @(posedge clk) begin
    if (reset || soft_rst) begin
      next_id_r <= REG_RESET;
    end else if (next_id_load) begin
      next_id_r <= next_id_value;
    end
  end

  // Slot registers; soft reset leaves them alone
  always_ff @(posedge clk) begin
    if (reset) begin
      tent_id_r <= REG_RESET;
      node_id_r <= REG_RESET;
      setup_1_r <= REG_RESET;
      setup_2_r <= REG_RESET;
    end else if (slot_we) begin
      if (slot_code == SLOT_TENTATIVE_ID) begin
        tent_id_r <= reg_wdata;
      end else if (slot_code == SLOT_NODE_ID) begin
        node_id_r <= reg_wdata;
      end else if (slot_code == SLOT_SETUP_1) begin
        setup_1_r <= reg_wdata;
      end else if (slot_code == SLOT_SETUP_2) begin
        setup_2_r <= reg_wdata;
      end
    end
  end

  // Read view at offset 7; next id is read only
  assign slot_q =
    (slot_code == SLOT_TENTATIVE_ID) ? tent_id_r :
    (slot_code == SLOT_NODE_ID)      ? node_id_r :
    (slot_code == SLOT_SETUP_1)      ? setup_1_r :
    (slot_code == SLOT_NEXT_ID)      ? next_id_r :
    (slot_code == SLOT_SETUP_2)      ? setup_2_r :
                                       UNDEF_READ;

  // Read views; undefined bits read as zero
  assign cfg_view      = {cfg_r, sel_low_r};
  assign sel_view      = {{(DATA_W-3){1'b0}}, slot_code};
  assign ptr_high_view = {access_direction, pointer_step_enable, 3'h0,
                          buffer_address[AW-1:AW-UPPER_W]};
  assign ptr_low_view  = buffer_address[DATA_W-1:0];

  // Read data mux, registered so it stands the cycle after the strobe
  assign rdata_nxt =
    !reg_rd      ? REG_RESET :
    hit_status   ? status_r :
    hit_diag     ? diag_r :
    hit_ptr_high ? ptr_high_view :
    hit_ptr_low  ? ptr_low_view :
    hit_data     ? (access_direction ? ram_q : UNDEF_READ) :
    hit_sel      ? sel_view :
    hit_cfg      ? cfg_view :
                   slot_q;

  always_ff @(posedge clk) begin
    if (reset) begin
      rdata_r <= REG_RESET;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // Buffer RAM and pointer
  tkrha_buffer_port #(
    .AW(AW)
  ) u_buffer (
    .clk                 (clk),
    .reset               (reset),
    .high_we             (reg_wr & hit_ptr_high),
    .low_we              (reg_wr & hit_ptr_low),
    .data_we             (reg_wr & hit_data),
    .data_re             (reg_rd & hit_data),
    .wdata               (reg_wdata),
    .access_direction    (access_direction),
    .pointer_step_enable (pointer_step_enable),
    .pointer             (buffer_address),
    .ram_q               (ram_q)
  );

  // Line outputs only move while transmit is enabled; pulse b also moves in backplane mode
  assign line_req[CH_PULSE_A] = tx_pulse_a;
  assign line_req[CH_PULSE_B] = tx_pulse_b;
  assign line_req[CH_DRIVER]  = tx_driver;

  tkrha_line_gate u_line_gate (
    .clk               (clk),
    .reset             (reset),
    .line_drive_enable (cfg_r[CFG_TX_BIT]),
    .backplane_mode    (cfg_r[CFG_BACKPLANE_BIT]),
    .request           (line_req),
    .drive_n           (line_n)
  );

  assign line_pulse_a_n  = line_n[CH_PULSE_A];
  assign line_pulse_b_n  = line_n[CH_PULSE_B];
  assign driver_enable_n = line_n[CH_DRIVER];

  // Engine controls straight from configuration flops
  assign soft_reset             = soft_rst;
  assign chained_command_enable = cfg_r[CFG_CHAIN_BIT];
  assign timeout_ext_hi         = cfg_r[CFG_ET_HI_BIT];
  assign timeout_ext_lo         = cfg_r[CFG_ET_LO_BIT];
  assign backplane_mode         = cfg_r[CFG_BACKPLANE_BIT];
  assign line_drive_enable      = cfg_r[CFG_TX_BIT];
  assign node_id                = node_id_r;
  assign tentative_id           = tent_id_r;
  assign setup_1                = setup_1_r;
  assign setup_2                = setup_2_r;
  assign reg_rdata              = rdata_r;

endmodule // tkrha_regs
`default_nettype wire

// >>> hw/tkrha_pkg.sv
// Shared constants for the token ring host register access block
package tkrha_pkg;

  // Register port geometry
  localparam int unsigned ADDR_W = 3;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned BUF_ADDR_W = 11;

  // Register offsets on the host port
  localparam logic [2:0] OFF_STATUS    = 3'h0;
  localparam logic [2:0] OFF_DIAG      = 3'h1;
  localparam logic [2:0] OFF_PTR_HIGH  = 3'h2;
  localparam logic [2:0] OFF_PTR_LOW   = 3'h3;
  localparam logic [2:0] OFF_BUF_DATA  = 3'h4;
  localparam logic [2:0] OFF_SLOT_SEL  = 3'h5;
  localparam logic [2:0] OFF_CONFIG    = 3'h6;
  localparam logic [2:0] OFF_SLOT      = 3'h7;

  // Pointer high register fields
  localparam int unsigned PH_DIR_BIT   = 7;
  localparam int unsigned PH_STEP_BIT  = 6;
  localparam int unsigned PH_UPPER_MSB = 2;
  localparam int unsigned UPPER_W      = 3;

  // Configuration register fields
  localparam int unsigned CFG_SOFT_RESET_BIT = 7;
  localparam int unsigned CFG_CHAIN_BIT      = 6;
  localparam int unsigned CFG_TX_BIT         = 5;
  localparam int unsigned CFG_ET_HI_BIT      = 4;
  localparam int unsigned CFG_ET_LO_BIT      = 3;
  localparam int unsigned CFG_BACKPLANE_BIT  = 2;
  localparam int unsigned CFG_KEEP_MSB       = 7;
  localparam int unsigned CFG_KEEP_LSB       = 2;
  localparam int unsigned SEL_LOW_W          = 2;

  // Slot selector codes for offset 7
  localparam logic [2:0] SLOT_TENTATIVE_ID = 3'h0;
  localparam logic [2:0] SLOT_NODE_ID      = 3'h1;
  localparam logic [2:0] SLOT_SETUP_1      = 3'h2;
  localparam logic [2:0] SLOT_NEXT_ID      = 3'h3;
  localparam logic [2:0] SLOT_SETUP_2      = 3'h4;

  // Reset values
  localparam logic [7:0] CONFIG_RESET  = 8'h00;
  localparam logic [7:0] REG_RESET     = 8'h00;
  localparam logic [7:0] UNDEF_READ    = 8'h00;
  localparam logic [2:0] SEL_RESET     = 3'h0;

  // Line output channels: pulse a, pulse b, driver enable
  localparam int unsigned LINE_CH    = 3;
  localparam int unsigned CH_PULSE_A = 0;
  localparam int unsigned CH_PULSE_B = 1;
  localparam int unsigned CH_DRIVER  = 2;

endpackage

// >>> hw/tkrha_buffer_port.sv
// Buffer RAM with its auto-stepping address pointer
`timescale 1ns/1ps
`default_nettype none
module tkrha_buffer_port
  import tkrha_pkg::*;
#(
  parameter int unsigned AW = BUF_ADDR_W
) (
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire logic              high_we,
  input  wire logic              low_we,
  input  wire logic              data_we,
  input  wire logic              data_re,
  input  wire logic [DATA_W-1:0] wdata,
  output logic                   access_direction,
  output logic                   pointer_step_enable,
  output logic [AW-1:0]          pointer,
  output logic [DATA_W-1:0]      ram_q
);

  logic [DATA_W-1:0] mem [0:(1<<AW)-1];
  logic              dir_r;
  logic              step_r;
  logic [AW-1:0]     ptr_r;
  logic [AW-1:0]     ptr_nxt;
  logic              do_write;
  logic              do_read;
  logic              stepped;

  // Direction bit gates which kind of data access is honoured
  assign do_write = data_we & ~dir_r;
  assign do_read  = data_re & dir_r;
  assign stepped  = (do_write | do_read) & step_r;
  assign ptr_nxt  = ptr_r + {{(AW-1){1'b0}}, 1'b1};

  // Pointer and mode bits; host pointer writes take priority over stepping
  always_ff @(posedge clk) begin
    if (reset) begin
      dir_r  <= 1'b0;
      step_r <= 1'b0;
      ptr_r  <= '0;
    end else begin
      if (high_we) begin
        dir_r  <= wdata[PH_DIR_BIT];
        step_r <= wdata[PH_STEP_BIT];
        ptr_r  <= {wdata[PH_UPPER_MSB:0], ptr_r[AW-UPPER_W-1:0]};
      end else if (low_we) begin
        ptr_r <= {ptr_r[AW-1:AW-UPPER_W], wdata};
      end else if (stepped) begin
        ptr_r <= ptr_nxt;
      end
    end
  end

  // Storage is not reset; contents are undefined after power up
  always_ff @(posedge clk) begin
    if (do_write) begin
      mem[ptr_r] <= wdata;
    end
  end

  assign ram_q               = mem[ptr_r];
  assign access_direction    = dir_r;
  assign pointer_step_enable = step_r;
  assign pointer             = ptr_r;

endmodule // tkrha_buffer_port
`default_nettype wire

// >>> hw/tkrha_line_gate.sv
// Transmit permission gate for the active-low line outputs
`timescale 1ns/1ps
`default_nettype none
module tkrha_line_gate
  import tkrha_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               reset,
  input  wire logic               line_drive_enable,
  input  wire logic               backplane_mode,
  input  wire logic [LINE_CH-1:0] request,
  output logic [LINE_CH-1:0]      drive_n
);

  logic [LINE_CH-1:0] permit;
  logic [LINE_CH-1:0] drive_nxt;

  // Pulse b is only gated outside backplane mode
  assign permit[CH_PULSE_A] = line_drive_enable;
  assign permit[CH_PULSE_B] = line_drive_enable | backplane_mode;
  assign permit[CH_DRIVER]  = line_drive_enable;

  // Per channel permit, active low towards the pins
  for (genvar ch = 0; ch < LINE_CH; ch++) begin : g_ch
    assign drive_nxt[ch] = ~(request[ch] & permit[ch]);
  end

  // Registered so the pins never glitch on a config write; one process owns the vector
  always_ff @(posedge clk) begin
    if (reset) begin
      drive_n <= '1;
    end else begin
      drive_n <= drive_nxt;
    end
  end

endmodule // tkrha_line_gate
`default_nettype wire

// >>> sim/tkrha_regs_properties.sv
// Port-level property checker for the host register bank
`timescale 1ns/1ps
`default_nettype none
module tkrha_regs_chk
  import tkrha_pkg::*;
#(
  parameter int unsigned AW = BUF_ADDR_W
) (
  input wire logic              clk,
  input wire logic              reset,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic [DATA_W-1:0] reg_rdata,
  input wire logic              soft_reset,
  input wire logic              line_drive_enable,
  input wire logic              backplane_mode,
  input wire logic [DATA_W-1:0] node_id,
  input wire logic [AW-1:0]     buffer_address,
  input wire logic              access_direction,
  input wire logic              pointer_step_enable,
  input wire logic              line_pulse_a_n,
  input wire logic              line_pulse_b_n,
  input wire logic              driver_enable_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  logic [2:0] code_r;
  // Decoded strobes; a refused data access does not count
  wire wr_hi = reg_wr && reg_addr == OFF_PTR_HIGH;
  wire wr_lo = reg_wr && reg_addr == OFF_PTR_LOW;
  wire wr_cfg = reg_wr && reg_addr == OFF_CONFIG;
  wire wr_sel = reg_wr && reg_addr == OFF_SLOT_SEL;
  wire at_rsv = reg_addr == OFF_SLOT && code_r > 3'h4;
  wire dacc = reg_addr == OFF_BUF_DATA && (reg_rd && access_direction || reg_wr && !access_direction);
  // Shadow of the slot code, since the selector is not a port
  always_ff @(posedge clk) begin
    if (reset) code_r <= 3'h0;
    else if (wr_sel) code_r <= reg_wdata[2:0];
    else if (wr_cfg) code_r <= {1'b0, reg_wdata[1:0]};
  end
  property p_dir; wr_hi |=> access_direction == $past(reg_wdata[7]); endproperty
  property p_hi; wr_hi |=> buffer_address == {$past(reg_wdata[2:0]), $past(buffer_address[7:0])}; endproperty
  property p_lo; wr_lo |=> buffer_address == {$past(buffer_address[AW-1:8]), $past(reg_wdata)}; endproperty
  property p_step; dacc && pointer_step_enable |=> buffer_address == AW'($past(buffer_address) + 1); endproperty
  property p_hold; dacc && !pointer_step_enable |=> $stable(buffer_address); endproperty
  property p_cfg; wr_cfg |=> soft_reset == $past(reg_wdata[7]) && backplane_mode == $past(reg_wdata[2]); endproperty
  property p_soft; soft_reset && !reg_wr |=> soft_reset && $stable(node_id) && $stable(line_drive_enable); endproperty
  property p_sel; reg_rd && reg_addr == OFF_SLOT_SEL |=> reg_rdata == {5'h00, code_r}; endproperty
  property p_rsv_wr; reg_wr && at_rsv |=> $stable(node_id); endproperty
  property p_rsv_rd; reg_rd && at_rsv |=> reg_rdata == UNDEF_READ; endproperty
  property p_quiet_a; (!line_drive_enable) [*2] |-> line_pulse_a_n && driver_enable_n; endproperty
  property p_quiet_b; (!line_drive_enable && !backplane_mode) [*2] |-> line_pulse_b_n; endproperty
  a_dir: assert property (p_dir) else $error("direction bit not taken");
  a_hi: assert property (p_hi) else $error("upper pointer bits wrong");
  a_lo: assert property (p_lo) else $error("lower pointer bits wrong");
  a_step: assert property (p_step) else $error("pointer did not step");
  a_hold: assert property (p_hold) else $error("pointer moved without step");
  a_cfg: assert property (p_cfg) else $error("configuration outputs wrong");
  a_soft: assert property (p_soft) else $error("soft reset disturbed config");
  a_sel: assert property (p_sel) else $error("slot code readback wrong");
  a_rsv_wr: assert property (p_rsv_wr) else $error("reserved slot write took");
  a_rsv_rd: assert property (p_rsv_rd) else $error("reserved slot read wrong");
  a_quiet_a: assert property (p_quiet_a) else $error("line active while disabled");
  a_quiet_b: assert property (p_quiet_b) else $error("pulse b active while disabled");
  c_wrap: cover property (dacc && pointer_step_enable && buffer_address == {AW{1'b1}});
  c_clr: cover property (wr_cfg && code_r[2]);
  c_soft: cover property (soft_reset ##1 !soft_reset);
endmodule // tkrha_regs_chk
bind tkrha_regs tkrha_regs_chk #(.AW(AW)) u_chk (
  .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .soft_reset(soft_reset),
  .line_drive_enable(line_drive_enable), .backplane_mode(backplane_mode),
  .node_id(node_id), .buffer_address(buffer_address), .access_direction(access_direction),
  .pointer_step_enable(pointer_step_enable), .line_pulse_a_n(line_pulse_a_n),
  .line_pulse_b_n(line_pulse_b_n), .driver_enable_n(driver_enable_n)
);
`default_nettype wire

// >>> sim/tkrha_host.sv
// Host controller model that works the register port
`timescale 1ns/1ps
`default_nettype none
module tkrha_host
  import tkrha_pkg::*;
(
  input  wire logic              clk,
  output var logic [ADDR_W-1:0]  reg_addr,
  output var logic [DATA_W-1:0]  reg_wdata,
  output var logic               reg_wr,
  output var logic               reg_rd,
  input  wire logic [DATA_W-1:0] reg_rdata
);
  // Quiet bus at time zero
  initial begin
    reg_addr = '0;
    reg_wdata = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // One-cycle write; released lines inverted so stale values never match
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    @(posedge clk);
    d = reg_rdata;
  endtask
endmodule // tkrha_host
`default_nettype wire

// >>> sim/tb_top.sv
// Self-checking bench for the host register bank
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import tkrha_pkg::*;
;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic [2:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, status_set, diag_set, next_id_value, node_id, d;
  logic        reg_wr, reg_rd, next_id_load, tx_pulse_a, tx_pulse_b, tx_driver, soft_reset;
  logic        chained_command_enable, timeout_ext_hi, timeout_ext_lo, backplane_mode;
  logic        line_drive_enable, access_direction, pointer_step_enable;
  logic        line_pulse_a_n, line_pulse_b_n, driver_enable_n;
  logic [10:0] buffer_address;
  logic [7:0]  tentative_id, setup_1, setup_2;
  int          bad_count = 0;
  int          num_checks = 0;
  always #5 clk = ~clk;
  tkrha_host host (.clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
  tkrha_regs uut (.clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .status_set, .diag_set, .next_id_load, .next_id_value, .tx_pulse_a, .tx_pulse_b,
    .tx_driver, .soft_reset, .chained_command_enable, .timeout_ext_hi, .timeout_ext_lo,
    .backplane_mode, .line_drive_enable, .node_id, .tentative_id, .setup_1, .setup_2,
    .buffer_address, .access_direction, .pointer_step_enable, .line_pulse_a_n,
    .line_pulse_b_n, .driver_enable_n);
  // Compare helpers
  task automatic chk(input logic [10:0] got, input logic [10:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [2:0] a, input logic [7:0] e);
    host.rd(a, d);
    chk(d, e);
  endtask
  // Let flop updates land before looking at outputs
  task automatic settle();
    repeat (2) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic t_reset();
    rchk(OFF_CONFIG, CONFIG_RESET);
    rchk(OFF_PTR_HIGH, REG_RESET);
    chk({line_pulse_a_n, line_pulse_b_n, driver_enable_n}, 3'h7);
    $display("test reset done");
  endtask
  // Wrap at the top, both directions, step off, refused write
  task automatic t_buffer();
    host.wr(OFF_PTR_HIGH, 8'h47);
    host.wr(OFF_PTR_LOW, 8'hfe);
    host.wr(OFF_BUF_DATA, 8'ha1);
    host.wr(OFF_BUF_DATA, 8'ha2);
    settle();
    chk(buffer_address, 11'h000);
    host.wr(OFF_PTR_HIGH, 8'hff);
    host.wr(OFF_PTR_LOW, 8'hfe);
    rchk(OFF_PTR_HIGH, 8'hc7);
    rchk(OFF_BUF_DATA, 8'ha1);
    rchk(OFF_BUF_DATA, 8'ha2);
    host.wr(OFF_PTR_HIGH, 8'h87);
    host.wr(OFF_PTR_LOW, 8'hff);
    host.wr(OFF_BUF_DATA, 8'h55);
    rchk(OFF_BUF_DATA, 8'ha2);
    rchk(OFF_BUF_DATA, 8'ha2);
    chk(buffer_address, 11'h7ff);
    $display("test buffer done");
  endtask
  // Every slot code, then the shared low code bits
  task automatic t_slot();
    logic [7:0] e;
    next_id_value <= 8'h5a;
    next_id_load <= 1'b1;
    @(posedge clk);
    next_id_load <= 1'b0;
    for (int c = 0; c < 8; c++) begin
      e = (c == 3) ? 8'h5a : (c > 4) ? UNDEF_READ : 8'h30 + 8'(c);
      host.wr(OFF_SLOT_SEL, 8'(c));
      host.wr(OFF_SLOT, 8'h30 + 8'(c));
      rchk(OFF_SLOT, e);
    end
    chk(tentative_id, 8'h30);
    chk(setup_1, 8'h32);
    chk(setup_2, 8'h34);
    host.wr(OFF_SLOT_SEL, 8'h05);
    rchk(OFF_CONFIG, 8'h01);
    host.wr(OFF_CONFIG, 8'h02);
    rchk(OFF_SLOT_SEL, 8'h02);
    rchk(OFF_SLOT, 8'h32);
    $display("test slot done");
  endtask
  // Config fields, then soft reset scope
  task automatic t_config();
    host.wr(OFF_CONFIG, 8'h7d);
    settle();
    chk({chained_command_enable, line_drive_enable, timeout_ext_hi, timeout_ext_lo, backplane_mode}, 5'h1f);
    rchk(OFF_CONFIG, 8'h7d);
    status_set <= 8'h81;
    diag_set <= 8'h42;
    @(posedge clk);
    status_set <= 8'h00;
    diag_set <= 8'h00;
    rchk(OFF_STATUS, 8'h81);
    host.wr(OFF_CONFIG, 8'hfd);
    rchk(OFF_STATUS, 8'h00);
    rchk(OFF_DIAG, 8'h00);
    host.wr(OFF_SLOT_SEL, 8'h03);
    rchk(OFF_SLOT, 8'h00);
    rchk(OFF_CONFIG, 8'hff);
    chk(node_id, 8'h31);
    host.wr(OFF_CONFIG, 8'h7c);
    settle();
    chk(soft_reset, 1'b0);
    $display("test config done");
  endtask
  // Line outputs under transmit enable and backplane mode
  task automatic t_line();
    host.wr(OFF_CONFIG, 8'h00);
    tx_pulse_a <= 1'b1;
    tx_pulse_b <= 1'b1;
    tx_driver <= 1'b1;
    settle();
    chk({line_pulse_a_n, line_pulse_b_n, driver_enable_n}, 3'h7);
    host.wr(OFF_CONFIG, 8'h20);
    settle();
    chk({line_pulse_a_n, line_pulse_b_n, driver_enable_n}, 3'h0);
    host.wr(OFF_CONFIG, 8'h04);
    settle();
    chk({line_pulse_a_n, line_pulse_b_n, driver_enable_n}, 3'h5);
    $display("test line done");
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    {status_set, diag_set, next_id_value} = '0;
    {next_id_load, tx_pulse_a, tx_pulse_b, tx_driver} = '0;
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    t_reset();
    t_buffer();
    t_slot();
    t_config();
    t_line();
    close_out();
  end
  // Watchdog, far beyond the roughly 180 cycles the tests take
  initial begin
    repeat (5000) @(posedge clk);
    bad_count++;
    close_out();
  end
endmodule // tb_top
`default_nettype wire
